//--- inc/mem_space_regs.vh
// Notes on behaviour
// - Direct addresses 0x80-0xFF reach special registers; below 0x80 reach lower RAM.
// - Indirect addresses above 0x7F reach upper RAM, separate from special registers.
// - RAM 0x00-0x1F forms four banks of eight; status bits 3,4 pick one.
// - Indirect operands take their address from register 0 or 1 of active bank.
// - RAM 0x20-0x2F doubles as bits 0x00-0x7F: 8*(byte-0x20)+position.
// - Bit or byte access decided only by the operand type given.
// - Special registers at addresses ending 0 or 8 allow bit access too.
// - Stack pointer holds last used slot; push writes pointer+1 then increments.
// - Reset loads stack pointer with 0x07; first push lands at 0x08.
// - 32-bit record register: push/inc in one, call two; pop/dec out one, return two.
// - Overflow and underflow of the record register are flagged to debug logic.
// - Program memory writable by external data move only when store control bit 0 set.
// - Relative branch: signed 8-bit offset added to next instruction address.
// - Absolute forms keep next address's 2K page, replace low 11 bits; long forms use 16.
// - Opcode 0xA5 behaves exactly like no-operation.
// - Compare-jump direct, immediate-acc, immediate-register: 3 cycles not taken, 4 taken.
// - Compare-jump with indirect RAM: 4 cycles not taken, 5 taken.
// - Decrement-jump register: 2 not taken, 3 taken; no-operation takes 1.
`ifndef MEM_SPACE_REGS_VH
`define MEM_SPACE_REGS_VH
`define SPR_BASE          8'h80
`define ADDR_STACK_PTR    8'h81
`define ADDR_STATUS_WORD  8'hD0
`define ADDR_STORE_CTL    8'h8F
`define STACK_PTR_RESET   8'h07
`define BANK_LO_BIT       3
`define BANK_HI_BIT       4
`define STORE_WE_BIT      0
`define BIT_RAM_BASE      8'h20
`define RECORD_WIDTH      32
`define RECORD_CNT_W      6
`define OP_NOP            8'h00
`define OP_SPARE_NOP      8'hA5
`define OP_CMPJ_DIR       8'hB5
`define OP_CMPJ_IMM_A     8'hB4
`define OP_CMPJ_IND_LO    8'hB6
`define OP_CMPJ_IND_HI    8'hB7
`define OP_CMPJ_REG_BASE  5'h17
`define OP_DECJ_REG_BASE  5'h1B
`define OP_DECJ_DIR       8'hD5
`endif

//--- src/stack_record.v
`timescale 1ns/1ns
`default_nettype none
`include "mem_space_regs.vh"
module stack_record
#(
   parameter WIDTH = `RECORD_WIDTH
)
(
   input  wire             clk,
   input  wire             nrst,
   input  wire             push_one,
   input  wire             push_two,
   input  wire             pop_one,
   input  wire             pop_two,
   input  wire             record_bit,
   output reg  [WIDTH-1:0] record_reg,
   output reg  [`RECORD_CNT_W-1:0] depth_reg,
   output reg              overflow_reg,
   output reg              underflow_reg
);
   // =====================================================================
   // Shift register with depth count; flags are sticky for debug logic
   // =====================================================================
   reg [`RECORD_CNT_W-1:0] depth_next;
   always @*
   begin
      depth_next = depth_reg;
      if (push_two)
         depth_next = depth_reg + 6'h02;
      else if (push_one)
         depth_next = depth_reg + 6'h01;
      else if (pop_two)
         depth_next = depth_reg - 6'h02;
      else if (pop_one)
         depth_next = depth_reg - 6'h01;
   end

   // Sticky flags hold until reset so debug sees them at full speed
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         record_reg    <= {WIDTH{1'b0}};
         depth_reg     <= 6'h00;
         overflow_reg  <= 1'b0;
         underflow_reg <= 1'b0;
      end
      else
      begin
         if (push_two)
         begin
            record_reg <= {record_reg[WIDTH-3:0], record_bit, 1'b1};
            if (depth_reg > 6'h1E)
               overflow_reg <= 1'b1;
         end
         else if (push_one)
         begin
            record_reg <= {record_reg[WIDTH-2:0], record_bit};
            if (depth_reg > 6'h1F)
               overflow_reg <= 1'b1;
         end
         else if (pop_two)
         begin
            record_reg <= {2'b00, record_reg[WIDTH-1:2]};
            if (depth_reg < 6'h02)
               underflow_reg <= 1'b1;
         end
         else if (pop_one)
         begin
            record_reg <= {1'b0, record_reg[WIDTH-1:1]};
            if (depth_reg == 6'h00)
               underflow_reg <= 1'b1;
         end
         // Depth saturates so one overflow does not mask later underflow
         if (depth_next[5] && !depth_reg[5] && (push_one || push_two))
            depth_reg <= 6'h20;
         else if ((pop_one || pop_two) && (depth_next > depth_reg))
            depth_reg <= 6'h00;
         else if (depth_reg == 6'h20 && (push_one || push_two))
            depth_reg <= 6'h20;
         else
            depth_reg <= depth_next;
      end
   end
endmodule
`default_nettype wire

//--- src/branch_timing.v
`timescale 1ns/1ns
`default_nettype none
`include "mem_space_regs.vh"
module branch_timing
(
   input  wire [7:0]  opcode,
   input  wire        taken,
   input  wire [15:0] next_pc,
   input  wire [7:0]  rel_offset,
   input  wire [10:0] abs_field,
   input  wire [15:0] long_target,
   output reg  [2:0]  cycles,
   output reg  [15:0] rel_target,
   output reg  [15:0] abs_target,
   output reg  [15:0] far_target
);
   // =====================================================================
   // Cycle counts per branch form and branch target arithmetic
   // =====================================================================
   always @*
   begin
      cycles = 3'd1;
      if (opcode == `OP_NOP || opcode == `OP_SPARE_NOP)
         cycles = 3'd1;
      else if (opcode == `OP_CMPJ_DIR || opcode == `OP_CMPJ_IMM_A ||
               opcode[7:3] == `OP_CMPJ_REG_BASE)
         cycles = taken ? 3'd4 : 3'd3;
      else if (opcode == `OP_CMPJ_IND_LO || opcode == `OP_CMPJ_IND_HI)
         cycles = taken ? 3'd5 : 3'd4;
      else if (opcode[7:3] == `OP_DECJ_REG_BASE)
         cycles = taken ? 3'd3 : 3'd2;
      else if (opcode == `OP_DECJ_DIR)
         cycles = taken ? 3'd4 : 3'd3;
      // Sign extend offset onto next instruction address
      rel_target = next_pc + {{8{rel_offset[7]}}, rel_offset};
      abs_target = {next_pc[15:11], abs_field};
      far_target = long_target;
   end
endmodule
`default_nettype wire

//--- src/mem_space_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "mem_space_regs.vh"
module mem_space_decode
(
   input  wire        clk,
   input  wire        nrst,
   // Data access request from execution
   input  wire        acc_valid,
   input  wire        acc_write,
   input  wire        acc_indirect,
   input  wire        acc_ind_sel,
   input  wire        acc_is_bit,
   input  wire [7:0]  acc_addr,
   input  wire [7:0]  acc_wdata,
   input  wire        acc_wbit,
   // Stack operations
   input  wire        stk_push,
   input  wire        stk_pop,
   input  wire        stk_inc,
   input  wire        stk_dec,
   input  wire        stk_call,
   input  wire        stk_ret,
   input  wire [7:0]  stk_wdata,
   // External data move toward program memory
   input  wire        xmove_write,
   input  wire [15:0] xmove_addr,
   input  wire [7:0]  xmove_data,
   // Branch evaluation
   input  wire [7:0]  opcode,
   input  wire        branch_taken,
   input  wire [15:0] next_pc,
   input  wire [7:0]  rel_offset,
   input  wire [10:0] abs_field,
   input  wire [15:0] long_target,
   // Results
   output reg  [7:0]  rd_data,
   output reg         rd_bit,
   output reg         rd_valid,
   output reg         spr_hit,
   output reg  [7:0]  spr_addr,
   output reg         spr_wr,
   output reg  [7:0]  spr_wdata,
   output reg         spr_bit_op,
   output reg  [7:0]  stack_top_pointer,
   output reg  [7:0]  program_status_word,
   output reg  [7:0]  program_store_control,
   output reg         pgm_wr,
   output reg  [15:0] pgm_addr,
   output reg  [7:0]  pgm_data,
   output reg  [2:0]  instr_cycles,
   output reg  [15:0] rel_target_reg,
   output reg  [15:0] abs_target_reg,
   output reg  [15:0] far_target_reg,
   output reg  [31:0] stack_record_reg,
   output reg         record_overflow,
   output reg         record_underflow
);
   // =====================================================================
   // Storage: 256 byte data RAM as flip-flops
   // =====================================================================
   reg [7:0] ram_reg [0:255];
   reg [7:0] stack_top_pointer_next;
   reg [7:0] ind_addr;
   reg [7:0] eff_addr;
   reg       to_spr;
   reg [7:0] bit_byte;
   reg [2:0] bit_pos;
   reg       bit_ok;
   integer   i;

   wire [31:0] rec_w;
   wire [5:0]  rec_depth;
   wire        rec_ovf;
   wire        rec_unf;
   wire [2:0]  cyc_w;
   wire [15:0] rel_w;
   wire [15:0] abs_w;
   wire [15:0] far_w;

   // =====================================================================
   // Helper functions
   // =====================================================================
   // Active bank base from the two select bits
   function [7:0] bank_base;
      input [7:0] status;
      begin
         bank_base = {3'b000, status[`BANK_HI_BIT], status[`BANK_LO_BIT], 3'b000};
      end
   endfunction

   // Bit address to byte address; bit 7 picks the special register half
   function [7:0] bit_to_byte;
      input [7:0] baddr;
      begin
         if (baddr[7])
            bit_to_byte = {baddr[7:3], 3'b000};
         else
            bit_to_byte = `BIT_RAM_BASE + {4'h0, baddr[6:3]};
      end
   endfunction

   // =====================================================================
   // Address decode
   // =====================================================================
   // Indirect pointer comes from register 0 or 1 of the live bank
   always @*
   begin
      ind_addr = ram_reg[bank_base(program_status_word) + {7'h00, acc_ind_sel}];
      bit_byte = bit_to_byte(acc_addr);
      bit_pos  = acc_addr[2:0];
      bit_ok   = 1'b1;
      if (acc_is_bit)
      begin
         eff_addr = bit_byte;
         to_spr   = acc_addr[7];
      end
      else if (acc_indirect)
      begin
         eff_addr = ind_addr;
         to_spr   = 1'b0;
      end
      else
      begin
         eff_addr = acc_addr;
         to_spr   = (acc_addr >= `SPR_BASE);
      end
   end

   // Stack pointer next value; wraps freely through all 256 bytes
   always @*
   begin
      stack_top_pointer_next = stack_top_pointer;
      if (stk_call)
         stack_top_pointer_next = stack_top_pointer + 8'h02;
      else if (stk_ret)
         stack_top_pointer_next = stack_top_pointer - 8'h02;
      else if (stk_push || stk_inc)
         stack_top_pointer_next = stack_top_pointer + 8'h01;
      else if (stk_pop || stk_dec)
         stack_top_pointer_next = stack_top_pointer - 8'h01;
      if (acc_valid && acc_write && !acc_indirect && !acc_is_bit &&
          acc_addr == `ADDR_STACK_PTR)
         stack_top_pointer_next = acc_wdata;
   end

   // =====================================================================
   // Sub-blocks
   // =====================================================================
   stack_record #(.WIDTH(`RECORD_WIDTH)) u_record
   (
      .clk           (clk),
      .nrst          (nrst),
      .push_one      (stk_push || stk_inc),
      .push_two      (stk_call),
      .pop_one       (stk_pop || stk_dec),
      .pop_two       (stk_ret),
      .record_bit    (stk_push),
      .record_reg    (rec_w),
      .depth_reg     (rec_depth),
      .overflow_reg  (rec_ovf),
      .underflow_reg (rec_unf)
   );

   branch_timing u_branch
   (
      .opcode      (opcode),
      .taken       (branch_taken),
      .next_pc     (next_pc),
      .rel_offset  (rel_offset),
      .abs_field   (abs_field),
      .long_target (long_target),
      .cycles      (cyc_w),
      .rel_target  (rel_w),
      .abs_target  (abs_w),
      .far_target  (far_w)
   );

   // =====================================================================
   // RAM, special register and stack storage
   // =====================================================================
   // Only the handful of core registers live here; others go out on spr_*
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (i = 0; i < 256; i = i + 1)
            ram_reg[i] <= 8'h00;
         stack_top_pointer     <= `STACK_PTR_RESET;
         program_status_word   <= 8'h00;
         program_store_control <= 8'h00;
         rd_data    <= 8'h00;
         rd_bit     <= 1'b0;
         rd_valid   <= 1'b0;
         spr_hit    <= 1'b0;
         spr_addr   <= 8'h00;
         spr_wr     <= 1'b0;
         spr_wdata  <= 8'h00;
         spr_bit_op <= 1'b0;
      end
      else
      begin
         stack_top_pointer <= stack_top_pointer_next;
         rd_valid <= acc_valid && !acc_write;
         spr_hit  <= acc_valid && to_spr;
         spr_addr <= eff_addr;
         spr_wr   <= acc_valid && acc_write && to_spr;
         spr_wdata  <= acc_wdata;
         // Non bit-capable special registers simply refuse the bit form
         spr_bit_op <= acc_valid && acc_is_bit && to_spr && (eff_addr[2:0] == 3'b000);
         // Push writes pointer+1 before the pointer itself moves
         if (stk_push)
            ram_reg[stack_top_pointer + 8'h01] <= stk_wdata;
         if (acc_valid && !to_spr)
         begin
            if (acc_write && acc_is_bit)
               ram_reg[eff_addr][bit_pos] <= acc_wbit;
            else if (acc_write)
               ram_reg[eff_addr] <= acc_wdata;
            rd_data <= ram_reg[eff_addr];
            rd_bit  <= ram_reg[eff_addr][bit_pos];
         end
         else if (acc_valid)
         begin
            if (acc_write && !acc_is_bit && eff_addr == `ADDR_STATUS_WORD)
               program_status_word <= acc_wdata;
            else if (acc_write && acc_is_bit && eff_addr == `ADDR_STATUS_WORD)
               program_status_word[bit_pos] <= acc_wbit;
            if (acc_write && !acc_is_bit && eff_addr == `ADDR_STORE_CTL)
               program_store_control <= acc_wdata;
            if (eff_addr == `ADDR_STACK_PTR)
               rd_data <= stack_top_pointer;
            else if (eff_addr == `ADDR_STATUS_WORD)
               rd_data <= program_status_word;
            else if (eff_addr == `ADDR_STORE_CTL)
               rd_data <= program_store_control;
            else
               rd_data <= 8'h00;
            rd_bit <= (eff_addr == `ADDR_STATUS_WORD) ? program_status_word[bit_pos] : 1'b0;
         end
      end
   end

   // =====================================================================
   // Program memory write path and registered results
   // =====================================================================
   // Store writes are gated so stray moves cannot corrupt code
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pgm_wr           <= 1'b0;
         pgm_addr         <= 16'h0000;
         pgm_data         <= 8'h00;
         instr_cycles     <= 3'd1;
         rel_target_reg   <= 16'h0000;
         abs_target_reg   <= 16'h0000;
         far_target_reg   <= 16'h0000;
         stack_record_reg <= 32'h00000000;
         record_overflow  <= 1'b0;
         record_underflow <= 1'b0;
      end
      else
      begin
         pgm_wr   <= xmove_write && program_store_control[`STORE_WE_BIT];
         pgm_addr <= xmove_addr;
         pgm_data <= xmove_data;
         instr_cycles   <= cyc_w;
         rel_target_reg <= rel_w;
         abs_target_reg <= abs_w;
         far_target_reg <= far_w;
         stack_record_reg <= rec_w;
         record_overflow  <= rec_ovf;
         record_underflow <= rec_unf;
      end
   end
endmodule
`default_nettype wire

//--- verification/mem_space_decode_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker for the data memory decoder
module mem_space_decode_monitor
(
   input wire        clk, nrst, acc_valid, acc_write, acc_indirect, acc_is_bit,
   input wire        stk_push, stk_pop, stk_inc, stk_dec, stk_call, stk_ret,
   input wire        xmove_write, branch_taken, spr_hit, pgm_wr, record_overflow,
   input wire [7:0]  acc_addr, xmove_data, opcode, rel_offset, spr_addr, pgm_data,
   input wire [7:0]  stack_top_pointer, program_store_control,
   input wire [15:0] xmove_addr, next_pc, long_target, pgm_addr,
   input wire [15:0] rel_target_reg, abs_target_reg, far_target_reg,
   input wire [10:0] abs_field,
   input wire [2:0]  instr_cycles
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic [15:0] rel_exp, abs_exp;
   wire         poke = acc_valid && acc_write && !acc_indirect && !acc_is_bit && acc_addr == 8'h81;
   wire         quiet = !stk_call && !stk_ret && !poke;
   // Targets one cycle behind their inputs, matching the registered outputs
   always_ff @(posedge clk)
   begin
      rel_exp <= next_pc + {{8{rel_offset[7]}}, rel_offset};
      abs_exp <= {next_pc[15:11], abs_field};
   end
   // Steps of a stack or store operation, free of any higher-priority request, and the direct and immediate compare-jump opcodes with decrement-jump direct
   sequence up_step;
      (stk_push || stk_inc) && quiet;
   endsequence
   sequence down_step;
      (stk_pop || stk_dec) && !stk_push && !stk_inc && quiet;
   endsequence
   sequence store_open;
      xmove_write && program_store_control[0];
   endsequence
   sequence cmp_op;
      opcode == 8'hB4 || opcode == 8'hB5 || opcode == 8'hD5 || opcode[7:3] == 5'h17;
   endsequence
   ptr_reset_a: assert property ($rose(nrst) |-> stack_top_pointer == 8'h07)
      else $error("pointer not 07 after reset");
   ptr_up_a: assert property (up_step |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
      else $error("pointer did not step up");
   ptr_down_a: assert property (down_step |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
      else $error("pointer did not step down");
   store_lock_a: assert property (xmove_write && !program_store_control[0] |=> !pgm_wr)
      else $error("store write while locked");
   store_pass_a: assert property (store_open |=> pgm_wr && pgm_addr == $past(xmove_addr) && pgm_data == $past(xmove_data))
      else $error("store write missing or wrong");
   nop_cyc_a: assert property (opcode == 8'h00 || opcode == 8'hA5 |=> instr_cycles == 3'h1)
      else $error("no-op cycle count wrong");
   cmp_cyc_a: assert property (cmp_op |=> instr_cycles == ($past(branch_taken) ? 3'h4 : 3'h3))
      else $error("compare jump cycle count wrong");
   ind_cyc_a: assert property (opcode[7:1] == 7'h5B |=> instr_cycles == ($past(branch_taken) ? 3'h5 : 3'h4))
      else $error("indirect compare cycle count wrong");
   dec_cyc_a: assert property (opcode[7:3] == 5'h1B |=> instr_cycles == ($past(branch_taken) ? 3'h3 : 3'h2))
      else $error("decrement jump cycle count wrong");
   target_calc_a: assert property (rel_target_reg == rel_exp && abs_target_reg == abs_exp && far_target_reg == $past(long_target))
      else $error("branch target wrong");
   spr_route_a: assert property (acc_valid && !acc_indirect && !acc_is_bit && acc_addr[7] |=> spr_hit && spr_addr == $past(acc_addr))
      else $error("direct upper access missed special space");
   ind_ram_a: assert property (acc_valid && acc_indirect |=> !spr_hit)
      else $error("indirect access reached special space");
   flag_hold_a: assert property (record_overflow |=> record_overflow)
      else $error("overflow flag dropped");
endmodule
bind mem_space_decode mem_space_decode_monitor mon (.*);
`default_nettype wire

//--- verification/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Peripheral and program-store side of the outward ports
module far_side_model
(
   input  wire         clk, nrst, spr_wr, pgm_wr,
   input  wire  [7:0]  spr_addr, spr_wdata, pgm_data,
   input  wire  [15:0] pgm_addr,
   output logic [15:0] last_spr,
   output logic [23:0] last_pgm,
   output logic [7:0]  pgm_count
);
   // Outward special writes at any address are logged here; reads of them get no data back
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         last_spr <= 16'h0000;
         last_pgm <= 24'h000000;
         pgm_count <= 8'h00;
      end
      else
      begin
         if (spr_wr)
            last_spr <= {spr_addr, spr_wdata};
         if (pgm_wr)
         begin
            last_pgm <= {pgm_addr, pgm_data};
            pgm_count <= pgm_count + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/mem_space_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mem_space_decode_tb;
   // ==========
   // Signals
   localparam CALL = 6'h20, RET = 6'h10, PUSH = 6'h08, INC = 6'h02, DEC = 6'h01;
   logic        clk, nrst, acc_valid, acc_write, acc_indirect, acc_ind_sel, acc_is_bit, acc_wbit;
   logic        stk_push, stk_pop, stk_inc, stk_dec, stk_call, stk_ret, xmove_write, branch_taken;
   logic [7:0]  acc_addr, acc_wdata, stk_wdata, xmove_data, opcode, rel_offset, d, p, pre;
   logic [15:0] xmove_addr, next_pc, long_target, a;
   logic [10:0] abs_field;
   logic [31:0] rng;
   logic [7:0]  ops [9] = '{8'h00, 8'hA5, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hD8, 8'hD5};
   wire  [7:0]  rd_data, spr_addr, spr_wdata, stack_top_pointer, program_status_word;
   wire  [7:0]  program_store_control, pgm_data, pgm_count;
   wire         rd_bit, rd_valid, spr_hit, spr_wr, spr_bit_op, pgm_wr;
   wire         record_overflow, record_underflow;
   wire  [15:0] pgm_addr, rel_target_reg, abs_target_reg, far_target_reg, last_spr;
   wire  [23:0] last_pgm;
   wire  [2:0]  instr_cycles;
   wire  [31:0] stack_record_reg;
   int          n_mismatch, tests_run, i, b;
   mem_space_decode uut (.*);
   far_side_model peer (.*);
   // ==========
   // Clock, helpers and bus tasks
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // Expected cycle count per opcode group
   function automatic logic [2:0] cyc_exp(input logic [7:0] op, input logic tk);
      if (op[7:1] == 7'h5B)
         return tk ? 3'h5 : 3'h4;
      if (op == 8'hB4 || op == 8'hB5 || op == 8'hD5 || op[7:3] == 5'h17)
         return tk ? 3'h4 : 3'h3;
      if (op[7:3] == 5'h1B)
         return tk ? 3'h3 : 3'h2;
      return 3'h1;
   endfunction
   function automatic logic [7:0] bit_of(input logic [7:0] byt, input logic [2:0] pos);
      return ((byt - 8'h20) << 3) | pos;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Inputs are quiet during reset so no request precedes its release
   task automatic do_reset();
      nrst = 1'b0;
      {acc_valid, acc_write, acc_indirect, acc_ind_sel, acc_is_bit, acc_wbit, acc_addr, acc_wdata,
       stk_push, stk_pop, stk_inc, stk_dec, stk_call, stk_ret, stk_wdata, xmove_write, xmove_addr,
       xmove_data, opcode, branch_taken, next_pc, rel_offset, abs_field, long_target} = '0;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
   endtask
   // Mode is write, indirect, pointer select, bit operand
   task automatic acc(input logic [3:0] m, input logic [7:0] ad, wd, input logic wb);
      @(negedge clk);
      {acc_valid, acc_write, acc_indirect, acc_ind_sel, acc_is_bit} = {1'b1, m};
      acc_addr = ad;
      acc_wdata = wd;
      acc_wbit = wb;
      @(negedge clk);
      acc_valid = 1'b0;
   endtask
   task automatic stk(input logic [5:0] w, input logic [7:0] wd);
      @(negedge clk);
      {stk_call, stk_ret, stk_push, stk_pop, stk_inc, stk_dec} = w;
      stk_wdata = wd;
      @(negedge clk);
      {stk_call, stk_ret, stk_push, stk_pop, stk_inc, stk_dec} = 6'h00;
   endtask
   task automatic xm(input logic [15:0] ad, input logic [7:0] wd);
      @(negedge clk);
      xmove_write = 1'b1;
      xmove_addr = ad;
      xmove_data = wd;
      @(negedge clk);
      xmove_write = 1'b0;
      @(negedge clk);
   endtask
   task automatic br(input logic [7:0] op, input logic tk, input logic [15:0] pc,
                     input logic [7:0] ro);
      logic [15:0] rt;
      @(negedge clk);
      opcode = op;
      branch_taken = tk;
      next_pc = pc;
      rel_offset = ro;
      abs_field = rnd();
      long_target = rnd();
      rt = pc + {{8{ro[7]}}, ro};
      @(negedge clk);
      chk(instr_cycles, cyc_exp(op, tk));
      chk(rel_target_reg, rt);
      chk({abs_target_reg, far_target_reg}, {pc[15:11], abs_field, long_target});
   endtask
   // ==========
   // Scenarios
   initial
   begin
      #1000000;
      n_mismatch++;
      close_out();
   end
   initial
   begin
      rng = 32'hACF561CE;
      n_mismatch = 0;
      tests_run = 0;
      do_reset();
      chk({stack_top_pointer, program_status_word, instr_cycles}, {16'h0700, 3'h1});
      // First push lands in register 0 of bank 1, then the pointer wraps at the top
      d = rnd();
      stk(PUSH, d);
      chk(stack_top_pointer, 8'h08);
      acc(4'h0, 8'h08, 8'h00, 1'b0);
      chk({rd_valid, spr_hit, rd_data}, {2'b10, d});
      acc(4'h0, 8'h81, 8'h00, 1'b0);
      chk({rd_valid, spr_hit, rd_data}, {2'b11, 8'h08});
      acc(4'h8, 8'h81, 8'hFF, 1'b0);
      d = rnd();
      stk(PUSH, d);
      chk(stack_top_pointer, 8'h00);
      acc(4'h0, 8'h00, 8'h00, 1'b0);
      chk(rd_data, d);
      stk(DEC, 8'h00);
      chk(stack_top_pointer, 8'hFF);
      // Each bank's pointer register 1 steers indirect access into upper RAM
      for (b = 0; b < 4; b++)
      begin
         acc(4'h8, 8'hD0, {3'h0, b[1:0], 3'h0}, 1'b0);
         chk(program_status_word[4:3], b[1:0]);
         d = rnd();
         p = {3'h5, d[4:0]};
         acc(4'h8, {3'h0, b[1:0], 3'h1}, p, 1'b0);
         d = rnd();
         acc(4'hE, 8'h00, d, 1'b0);
         acc(4'h8, p, ~d, 1'b0);
         acc(4'h6, 8'h00, 8'h00, 1'b0);
         chk({spr_hit, rd_data, last_spr}, {1'b0, d, p, ~d});
      end
      // Bit view of 0x20-0x2F against the byte view, top bit first
      for (i = 0; i < 8; i++)
      begin
         a = (i == 0) ? 16'h007F : rnd();
         p = {4'h2, a[3:0]};
         d = rnd();
         acc(4'h8, p, d, 1'b0);
         acc(4'h1, bit_of(p, a[6:4]), 8'h00, 1'b0);
         chk(rd_bit, d[a[6:4]]);
         acc(4'h9, bit_of(p, a[6:4]), 8'h00, ~d[a[6:4]]);
         acc(4'h0, p, 8'h00, 1'b0);
         chk(rd_data, d ^ (8'h01 << a[6:4]));
      end
      acc(4'h9, 8'hD3, 8'h00, 1'b0);
      chk(program_status_word[4:3], 2'b10);
      acc(4'h9, 8'hA5, 8'h00, 1'b1);
      chk({spr_bit_op, spr_addr}, 9'h1A0);
      // Store writes pass only while the enable bit is set; this test writes to an address below 0xFE00
      a = rnd() % 32'hFE00;
      d = rnd();
      pre = pgm_count;
      xm(a, d);
      chk(pgm_count, pre);
      acc(4'h8, 8'h8F, 8'h01, 1'b0);
      chk(program_store_control[0], 1'b1);
      xm(a, d);
      chk({pgm_count, last_pgm}, {pre + 8'h01, a, d});
      br(8'hB6, 1'b1, 16'h07FF, 8'h80);
      for (i = 0; i < 18; i++)
      begin
         d = ops[i / 2];
         if (d[3])
            d[2:0] = rnd();
         br(d, i[0], rnd(), rnd());
      end
      // Record depth: a call takes two bits and a return gives two back
      do_reset();
      stk(CALL, 8'h00);
      stk(RET, 8'h00);
      repeat (3) @(negedge clk);
      chk(record_underflow, 1'b0);
      stk(RET, 8'h00);
      repeat (3) @(negedge clk);
      chk(record_underflow, 1'b1);
      do_reset();
      repeat (16) stk(CALL, 8'h00);
      repeat (3) @(negedge clk);
      chk(record_overflow, 1'b0);
      chk(stack_record_reg, 32'h55555555);
      stk(INC, 8'h00);
      repeat (4) @(negedge clk);
      chk(record_overflow, 1'b1);
      chk(stack_record_reg, 32'hAAAAAAAA);
      close_out();
   end
endmodule
`default_nettype wire
